//--- bpir_host_model.sv
/*
 * link-side host model: accepts interrupt messages after a stall and
 * broadcasts end-of-interrupt messages when the bench asks.
 * assumes it shares the link clock and reset with the redirector.
 */
module bpir_host_model
(
    // link clock and reset
    input  wire logic        lclk_i,
    input  wire logic        reset_n_i,
    // message port
    input  wire logic        msg_valid_i,
    output logic             msg_accept_o,
    input  wire logic [3:0]  stall_i,
    // end-of-interrupt broadcast
    output logic             eoi_valid_o,
    output logic [31:8]      eoi_info_o
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt;
    int msg_cnt;
    initial begin
        eoi_valid_o = 1'b0;
        eoi_info_o = 24'h000000;
    end
    always_ff @(posedge lclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            msg_accept_o <= 1'b0;
            wait_cnt <= 0;
            msg_cnt <= 0;
        end else if (msg_accept_o) begin
            msg_accept_o <= 1'b0;
            wait_cnt <= 0;
            msg_cnt <= msg_cnt + 1;
        end else if (msg_valid_i) begin
            if (wait_cnt >= int'(stall_i)) begin
                msg_accept_o <= 1'b1;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
    // info lines show the inverse once released, then four idle cycles
    task automatic send_eoi(input logic [31:8] info);
        @(posedge lclk_i);
        eoi_valid_o <= 1'b1;
        eoi_info_o <= info;
        @(posedge lclk_i);
        eoi_valid_o <= 1'b0;
        eoi_info_o <= ~info;
        repeat (4) @(posedge lclk_i);
    endtask
endmodule

//--- bpir_pkg.sv
/*
 * constants for the pci interrupt redirector: register map, field
 * positions, reset values, link packet layout and message type codes.
 * assumes a single-word register port and a parallel link message port.
 */
// Summary of operation
// - four interrupt inputs per bridge become link messages
// - masked inputs drive shared legacy outputs when combined
// - messages carry the bridge's own unit identifier
// - re-encoded type in bits 4:2, bit 7 low
// - destination mode bit 6, trigger mode bit 5
// - vector in bit time 5, destination info 15:8
// - status, polarity, pending, mask never sent
// - extended flag and info bits copied into packets
// - level entries set pending bit on assertion
// - matching end-of-interrupt clears pending in either bridge
// - still asserted after clear re-sets pending, resends
// - edge entries ignore end-of-interrupt broadcasts
// - entries independent; simultaneous messages sent lowest entry first
// - messages held over disconnect, never discarded
package bpir_pkg;
    localparam int          NUM_IN        = 4;
    localparam int          NUM_ENT       = 8;
    localparam int          UID_W         = 5;
    // register map, byte addresses
    localparam logic [7:0]  OFF_ENT_BASE  = 8'h00;
    localparam logic [7:0]  ENT_STRIDE    = 8'h08;
    localparam logic [7:0]  OFF_HI_DELTA  = 8'h04;
    localparam logic [7:0]  OFF_EXT_BASE  = 8'h40;
    localparam logic [7:0]  OFF_STATUS    = 8'h50;
    // entry low word fields
    localparam int          F_VEC         = 0;
    localparam int          F_MT          = 8;
    localparam int          F_DM          = 11;
    localparam int          F_DS          = 12;
    localparam int          F_POL         = 13;
    localparam int          F_IRR         = 14;
    localparam int          F_TM          = 15;
    localparam int          F_IM          = 16;
    // entry high word
    localparam int          F_DESTINATION        = 24;
    // extended control word
    localparam int          F_PASS_POSTED_WRITE_FLAG      = 0;
    localparam int          F_INFO7       = 1;
    localparam int          F_COMBINE     = 2;
    // status word
    localparam int          F_ST_BUSY     = 8;
    localparam int          F_ST_DISC     = 9;
    // reset values: entries masked, active low, level
    localparam logic [7:0]  RST_VEC       = 8'h00;
    localparam logic [2:0]  RST_MT        = 3'h0;
    localparam logic        RST_POL       = 1'b1;
    localparam logic        RST_TM        = 1'b1;
    localparam logic        RST_IM        = 1'b1;
    // link packet bit time 3 positions
    localparam int          BT3_MT        = 2;
    localparam int          BT3_REQUEST_END_OF_INTERRUPT_BIT     = 5;
    localparam int          BT3_DM        = 6;
    localparam int          BT3_MT3       = 7;
    localparam logic [7:0]  EOI_NO_DESTINATION   = 8'h00;
    // entry message type codes and their link codes
    localparam logic [2:0]  MT_FIXED      = 3'h0;
    localparam logic [2:0]  MT_LOWEST     = 3'h1;
    localparam logic [2:0]  MT_SMI        = 3'h2;
    localparam logic [2:0]  MT_NMI        = 3'h4;
    localparam logic [2:0]  MT_INIT       = 3'h5;
    localparam logic [2:0]  MT_EXTINT     = 3'h7;
    localparam logic [2:0]  LMT_FIXED     = 3'h0;
    localparam logic [2:0]  LMT_LOWEST    = 3'h1;
    localparam logic [2:0]  LMT_SMI       = 3'h2;
    localparam logic [2:0]  LMT_NMI       = 3'h3;
    localparam logic [2:0]  LMT_INIT      = 3'h4;
    localparam logic [2:0]  LMT_EXTINT    = 3'h5;
    localparam logic [2:0]  LMT_RSVD      = 3'h6;
    // first link unit identifier, arbitrary value
    localparam logic [4:0]  UNIT_ID_FIRST = 5'h01;
endpackage

//--- bpir_redirector.sv
/*
 * two-bridge pci interrupt redirector: eight redirection entries, level
 * pending bits, end-of-interrupt matching, legacy combining and a link
 * message port on the link clock.
 * assumes the link clock is unrelated to mclk_i and the register port
 * master follows single-cycle strobes.
 */
// The address-and-strobe port and the register addresses were decided locally.
module bpir_redirector
    import bpir_pkg::*;
(
    // clocks and reset
    input  wire logic                     mclk_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     lclk_i,
    // register port
    input  wire logic [7:0]               reg_addr_i,
    input  wire logic [31:0]              reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [31:0]              reg_rdata_o,
    // pins
    input  wire logic [bpir_pkg::NUM_ENT-1:0] pci_interrupt_inputs_n_i,
    input  wire logic                     link_disconnect_request_n_i,
    output logic      [bpir_pkg::NUM_IN-1:0]  legacy_shared_interrupt_outputs_n_o,
    // link message port, lclk_i domain
    output logic                          msg_valid_o,
    input  wire logic                     msg_accept_i,
    output logic      [bpir_pkg::UID_W-1:0]   msg_unit_id_o,
    output logic                          msg_pass_posted_write_flag_o,
    output logic      [7:0]               msg_bt3_o,
    output logic      [55:0]              msg_info_o,
    output logic      [7:0]               msg_vector_o,
    // end-of-interrupt broadcast, lclk_i domain
    input  wire logic                     eoi_valid_i,
    input  wire logic [31:8]              eoi_info_i
);
    import bpir_pkg::*;

    function automatic logic [2:0] mt_encode(input logic [2:0] mt);
        unique case (mt)
            MT_FIXED:  mt_encode = LMT_FIXED;
            MT_LOWEST: mt_encode = LMT_LOWEST;
            MT_SMI:    mt_encode = LMT_SMI;
            MT_NMI:    mt_encode = LMT_NMI;
            MT_INIT:   mt_encode = LMT_INIT;
            MT_EXTINT: mt_encode = LMT_EXTINT;
            default:   mt_encode = LMT_RSVD;
        endcase
    endfunction

    function automatic logic [2:0] first_set(input logic [NUM_ENT-1:0] v);
        first_set = 3'h0;
        for (int k = NUM_ENT - 1; k >= 0; k--) begin
            if (v[k]) begin
                first_set = 3'(k);
            end
        end
    endfunction

    // entry storage
    logic [7:0]          vec_ff   [NUM_ENT];
    logic [2:0]          mt_ff    [NUM_ENT];
    logic [7:0]          destination_ff  [NUM_ENT];
    logic [NUM_ENT-1:0]  dm_ff;
    logic [NUM_ENT-1:0]  pol_ff;
    logic [NUM_ENT-1:0]  tm_ff;
    logic [NUM_ENT-1:0]  im_ff;
    logic [NUM_ENT-1:0]  irr_ff;
    logic [NUM_ENT-1:0]  req_ff;
    logic [31:0]         ext_hi_ff [2];
    logic [2:0]          ext_ctl_ff [2];

    // pin synchronisers and detection
    logic [NUM_ENT-1:0]  pin_s1_ff;
    logic [NUM_ENT-1:0]  pin_s2_ff;
    logic [NUM_ENT-1:0]  asserted;
    logic [NUM_ENT-1:0]  asserted_prev_ff;
    logic                disc_s1_ff;
    logic                disc_s2_ff;

    // crossings
    logic                req_tgl_ff;
    logic                ack_s1_ff;
    logic                ack_s2_ff;
    logic                eoi_s1_ff;
    logic                eoi_s2_ff;
    logic                eoi_s3_ff;
    logic                eoi_hit;
    logic                busy;
    logic                launch;
    logic [2:0]          sel;
    logic [NUM_ENT-1:0]  match;
    logic [NUM_ENT-1:0]  set_irr;
    logic [NUM_ENT-1:0]  set_req;

    // packet held for the link side while busy
    logic [UID_W-1:0]    p_unit_ff;
    logic                p_pass_posted_write_flag_ff;
    logic [7:0]          p_bt3_ff;
    logic [55:0]         p_info_ff;
    logic [7:0]          p_vec_ff;
    logic [2:0]          p_sel_ff;

    // link domain
    logic                lreq_s1_ff;
    logic                lreq_s2_ff;
    logic                ack_tgl_l_ff;
    logic                eoi_tgl_l_ff;
    logic [31:8]         eoi_info_l_ff;
    logic [31:0]         nxt_rdata;

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_s1_ff  <= '1;
            pin_s2_ff  <= '1;
            disc_s1_ff <= 1'b0;
            disc_s2_ff <= 1'b0;
        end else begin
            pin_s1_ff  <= pci_interrupt_inputs_n_i;
            pin_s2_ff  <= pin_s1_ff;
            disc_s1_ff <= ~link_disconnect_request_n_i;
            disc_s2_ff <= disc_s1_ff;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            eoi_s1_ff <= 1'b0;
            eoi_s2_ff <= 1'b0;
            eoi_s3_ff <= 1'b0;
        end else begin
            ack_s1_ff <= ack_tgl_l_ff;
            ack_s2_ff <= ack_s1_ff;
            eoi_s1_ff <= eoi_tgl_l_ff;
            eoi_s2_ff <= eoi_s1_ff;
            eoi_s3_ff <= eoi_s2_ff;
        end
    end

    assign eoi_hit = eoi_s2_ff ^ eoi_s3_ff;
    assign busy    = req_tgl_ff ^ ack_s2_ff;
    assign launch  = ~busy & ~disc_s2_ff & (|req_ff);
    assign sel     = first_set(req_ff);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ENT; gi++) begin : g_ent
            localparam logic [7:0] LO = 8'(OFF_ENT_BASE + gi * ENT_STRIDE);
            localparam int         BR = gi / NUM_IN;
            logic vec_match;
            assign asserted[gi] = pol_ff[gi] ? ~pin_s2_ff[gi] : pin_s2_ff[gi];
            assign vec_match = (eoi_info_l_ff[31:16] == {ext_hi_ff[BR][7:0], vec_ff[gi]});
            assign match[gi] = vec_match & ((eoi_info_l_ff[15:8] == EOI_NO_DESTINATION) |
                                            (eoi_info_l_ff[15:8] == destination_ff[gi]));
            assign set_irr[gi] = tm_ff[gi] & ~im_ff[gi] & asserted[gi] & ~irr_ff[gi];
            assign set_req[gi] = tm_ff[gi] ? set_irr[gi]
                               : ~im_ff[gi] & asserted[gi] & ~asserted_prev_ff[gi];

            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    vec_ff[gi]  <= RST_VEC;
                    mt_ff[gi]   <= RST_MT;
                    dm_ff[gi]   <= 1'b0;
                    pol_ff[gi]  <= RST_POL;
                    tm_ff[gi]   <= RST_TM;
                    im_ff[gi]   <= RST_IM;
                    destination_ff[gi] <= 8'h00;
                end else if (reg_wr_i && reg_addr_i == LO) begin
                    vec_ff[gi]  <= reg_wdata_i[F_VEC +: 8];
                    mt_ff[gi]   <= reg_wdata_i[F_MT +: 3];
                    dm_ff[gi]   <= reg_wdata_i[F_DM];
                    pol_ff[gi]  <= reg_wdata_i[F_POL];
                    tm_ff[gi]   <= reg_wdata_i[F_TM];
                    im_ff[gi]   <= reg_wdata_i[F_IM];
                end else if (reg_wr_i && reg_addr_i == 8'(LO + OFF_HI_DELTA)) begin
                    destination_ff[gi] <= reg_wdata_i[F_DESTINATION +: 8];
                end
            end

            // pending bit: a fresh assertion wins over a clearing broadcast
            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    irr_ff[gi] <= 1'b0;
                end else if (set_irr[gi]) begin
                    irr_ff[gi] <= 1'b1;
                end else if (eoi_hit && match[gi] && tm_ff[gi]) begin
                    irr_ff[gi] <= 1'b0;
                end
            end

            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    req_ff[gi]           <= 1'b0;
                    asserted_prev_ff[gi] <= 1'b0;
                end else begin
                    asserted_prev_ff[gi] <= asserted[gi];
                    if (set_req[gi]) begin
                        req_ff[gi] <= 1'b1;
                    end else if (launch && sel == 3'(gi)) begin
                        req_ff[gi] <= 1'b0;
                    end
                end
            end

            a_irr_level_set: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
                tm_ff[gi] && !im_ff[gi] && asserted[gi] && !irr_ff[gi] |=> irr_ff[gi] && req_ff[gi])
                else $error("level assertion did not set pending");
            a_eoi_clear_irr: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
                eoi_hit && match[gi] && tm_ff[gi] && !set_irr[gi] |=> !irr_ff[gi])
                else $error("matching end-of-interrupt left pending set");
            a_edge_eoi_ignored: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
                !tm_ff[gi] && irr_ff[gi] && !(reg_wr_i && reg_addr_i == LO) |=> irr_ff[gi])
                else $error("edge entry pending changed");
            a_req_held: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
                req_ff[gi] && !(launch && sel == 3'(gi)) |=> req_ff[gi])
                else $error("pending message dropped");
            a_masked_no_msg: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
                im_ff[gi] && $past(im_ff[gi]) |-> !$rose(req_ff[gi]))
                else $error("masked entry raised a message");
        end
    endgenerate

    generate
        for (gi = 0; gi < 2; gi++) begin : g_ext
            localparam logic [7:0] EB = 8'(OFF_EXT_BASE + gi * ENT_STRIDE);
            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    ext_hi_ff[gi]  <= 32'h0000_0000;
                    ext_ctl_ff[gi] <= 3'h0;
                end else if (reg_wr_i && reg_addr_i == EB) begin
                    ext_hi_ff[gi]  <= reg_wdata_i;
                end else if (reg_wr_i && reg_addr_i == 8'(EB + OFF_HI_DELTA)) begin
                    ext_ctl_ff[gi] <= reg_wdata_i[2:0];
                end
            end
        end
    endgenerate

    // packet build at launch; status, polarity, pending, mask left out
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_tgl_ff  <= 1'b0;
            p_unit_ff   <= '0;
            p_pass_posted_write_flag_ff <= 1'b0;
            p_bt3_ff    <= 8'h00;
            p_info_ff   <= '0;
            p_vec_ff    <= 8'h00;
            p_sel_ff    <= 3'h0;
        end else if (launch) begin
            req_tgl_ff                <= ~req_tgl_ff;
            p_sel_ff                  <= sel;
            p_unit_ff                 <= UNIT_ID_FIRST + UID_W'(sel[2]);
            p_pass_posted_write_flag_ff               <= ext_ctl_ff[sel[2]][F_PASS_POSTED_WRITE_FLAG];
            p_bt3_ff                  <= 8'h00;
            p_bt3_ff[BT3_MT +: 3]     <= mt_encode(mt_ff[sel]);
            p_bt3_ff[BT3_REQUEST_END_OF_INTERRUPT_BIT]       <= tm_ff[sel];
            p_bt3_ff[BT3_DM]          <= dm_ff[sel];
            p_info_ff                 <= '0;
            p_info_ff[55:24]          <= ext_hi_ff[sel[2]];
            p_info_ff[15:8]           <= destination_ff[sel];
            p_info_ff[7]              <= ext_ctl_ff[sel[2]][F_INFO7];
            p_vec_ff                  <= vec_ff[sel];
        end
    end

    logic launch_tm;
    assign launch_tm = tm_ff[sel];

    a_unit_id_map: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        launch |=> p_unit_ff == (p_sel_ff[2] ? UNIT_ID_FIRST + 5'h01 : UNIT_ID_FIRST))
        else $error("wrong unit identifier for bridge");
    a_request_end_of_interrupt_bit_from_tm: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        launch |=> p_bt3_ff[BT3_REQUEST_END_OF_INTERRUPT_BIT] == $past(launch_tm) && p_info_ff[23:16] == 8'h00)
        else $error("request end-of-interrupt bit mismatch");
    a_disc_holds: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        disc_s2_ff && !busy |=> !busy)
        else $error("message launched during disconnect");

    // legacy combining, active low outputs
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            legacy_shared_interrupt_outputs_n_o <= '1;
        end else begin
            for (int j = 0; j < NUM_IN; j++) begin
                legacy_shared_interrupt_outputs_n_o[j] <= ~(
                    (asserted[j] & im_ff[j] & ext_ctl_ff[0][F_COMBINE]) |
                    (asserted[NUM_IN + j] & im_ff[NUM_IN + j] & ext_ctl_ff[1][F_COMBINE]));
            end
        end
    end

    a_legacy_out: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
        asserted[0] && im_ff[0] && ext_ctl_ff[0][F_COMBINE] |=>
            !legacy_shared_interrupt_outputs_n_o[0])
        else $error("legacy output not asserted");

    // register read path
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        for (int k = 0; k < NUM_ENT; k++) begin
            if (reg_addr_i == 8'(OFF_ENT_BASE + k * ENT_STRIDE)) begin
                nxt_rdata[F_VEC +: 8] = vec_ff[k];
                nxt_rdata[F_MT +: 3]  = mt_ff[k];
                nxt_rdata[F_DM]       = dm_ff[k];
                nxt_rdata[F_DS]       = req_ff[k];
                nxt_rdata[F_POL]      = pol_ff[k];
                nxt_rdata[F_IRR]      = irr_ff[k];
                nxt_rdata[F_TM]       = tm_ff[k];
                nxt_rdata[F_IM]       = im_ff[k];
            end
            if (reg_addr_i == 8'(OFF_ENT_BASE + k * ENT_STRIDE + OFF_HI_DELTA)) begin
                nxt_rdata[F_DESTINATION +: 8] = destination_ff[k];
            end
        end
        for (int b = 0; b < 2; b++) begin
            if (reg_addr_i == 8'(OFF_EXT_BASE + b * ENT_STRIDE)) begin
                nxt_rdata = ext_hi_ff[b];
            end
            if (reg_addr_i == 8'(OFF_EXT_BASE + b * ENT_STRIDE + OFF_HI_DELTA)) begin
                nxt_rdata[2:0] = ext_ctl_ff[b];
            end
        end
        if (reg_addr_i == OFF_STATUS) begin
            nxt_rdata[NUM_ENT-1:0] = req_ff;
            nxt_rdata[F_ST_BUSY]   = busy;
            nxt_rdata[F_ST_DISC]   = disc_s2_ff;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end else begin
            reg_rdata_o <= 32'h0000_0000;
        end
    end

    // link side: hold a message until the link takes it
    always_ff @(posedge lclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lreq_s1_ff <= 1'b0;
            lreq_s2_ff <= 1'b0;
        end else begin
            lreq_s1_ff <= req_tgl_ff;
            lreq_s2_ff <= lreq_s1_ff;
        end
    end

    always_ff @(posedge lclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            msg_valid_o   <= 1'b0;
            ack_tgl_l_ff  <= 1'b0;
            msg_unit_id_o <= '0;
            msg_pass_posted_write_flag_o  <= 1'b0;
            msg_bt3_o     <= 8'h00;
            msg_info_o    <= '0;
            msg_vector_o  <= 8'h00;
        end else if (msg_valid_o) begin
            if (msg_accept_i) begin
                msg_valid_o  <= 1'b0;
                ack_tgl_l_ff <= ~ack_tgl_l_ff;
            end
        end else if (lreq_s2_ff != ack_tgl_l_ff) begin
            msg_valid_o   <= 1'b1;
            msg_unit_id_o <= p_unit_ff;
            msg_pass_posted_write_flag_o  <= p_pass_posted_write_flag_ff;
            msg_bt3_o     <= p_bt3_ff;
            msg_info_o    <= p_info_ff;
            msg_vector_o  <= p_vec_ff;
        end
    end

    always_ff @(posedge lclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            eoi_tgl_l_ff  <= 1'b0;
            eoi_info_l_ff <= '0;
        end else if (eoi_valid_i) begin
            eoi_tgl_l_ff  <= ~eoi_tgl_l_ff;
            eoi_info_l_ff <= eoi_info_i;
        end
    end

    a_bt3_bit7_low: assert property (@(posedge lclk_i) disable iff (!reset_n_i)
        msg_valid_o |-> !msg_bt3_o[BT3_MT3] && msg_info_o[6:0] == 7'h00)
        else $error("bit time 3 bit 7 or low info bits set");
    a_msg_stable: assert property (@(posedge lclk_i) disable iff (!reset_n_i)
        msg_valid_o && !msg_accept_i |=> msg_valid_o && $stable(msg_vector_o)
            && $stable(msg_bt3_o))
        else $error("message changed before accept");
endmodule

//--- bpir_redirector_test.sv
/*
 * self-checking bench for the interrupt redirector: register port,
 * pins, legacy outputs and link traffic through the host model.
 * assumes bpir_pkg and bpir_host_model are compiled first.
 */
module bpir_redirector_test;
    timeunit 1ns;
    timeprecision 1ps;
    import bpir_pkg::*;
    logic        mclk = 1'b0;
    logic        lclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        disc_n = 1'b1;
    logic        valid;
    logic        accept;
    logic        ppw;
    logic        eoi_v;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] got;
    logic [7:0]  pins_n = 8'hFF;
    logic [3:0]  legacy_n;
    logic [3:0]  stall = 4'h0;
    logic [4:0]  uid;
    logic [7:0]  bt3;
    logic [7:0]  vec;
    logic [55:0] info;
    logic [31:8] eoi_i;
    logic [21:0] head;
    logic [55:0] body;
    int          errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    always #10 mclk = ~mclk;
    always #32 lclk = ~lclk;
    bpir_redirector i_bpir_redirector (.mclk_i(mclk), .reset_n_i(rst_n), .lclk_i(lclk),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .pci_interrupt_inputs_n_i(pins_n),
        .link_disconnect_request_n_i(disc_n), .legacy_shared_interrupt_outputs_n_o(legacy_n),
        .msg_valid_o(valid), .msg_accept_i(accept), .msg_unit_id_o(uid), .msg_pass_posted_write_flag_o(ppw),
        .msg_bt3_o(bt3), .msg_info_o(info), .msg_vector_o(vec), .eoi_valid_i(eoi_v),
        .eoi_info_i(eoi_i));
    bpir_host_model i_bpir_host_model (.lclk_i(lclk), .reset_n_i(rst_n), .msg_valid_i(valid),
        .msg_accept_o(accept), .stall_i(stall), .eoi_valid_o(eoi_v), .eoi_info_o(eoi_i));
    always @(posedge lclk) begin
        if (valid === 1'b1 && accept === 1'b1) begin
            head <= {uid, ppw, bt3, vec};
            body <= info;
        end
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        @(negedge mclk);
        d = rdata;
    endtask
    task automatic wait_msgs(input int n);
        for (int k = 0; k < 300 && i_bpir_host_model.msg_cnt < n; k++) @(posedge mclk);
        chk("msg_count", 64'(i_bpir_host_model.msg_cnt), 64'(n));
    endtask
    task automatic t_legacy();
        reg_write(8'h44, 32'h0000_0007);
        pins_n <= 8'hFD;
        settle(8);
        chk("legacy", 64'(legacy_n), 64'hD);
        wait_msgs(0);
        pins_n <= 8'hFF;
        settle(8);
        chk("legacy", 64'(legacy_n), 64'hF);
    endtask
    task automatic t_level();
        reg_write(8'h00, 32'h0000_AC5A);
        reg_write(8'h04, 32'h3300_0000);
        reg_write(8'h40, 32'h1234_5678);
        pins_n <= 8'hFE;
        wait_msgs(1);
        chk("head", 64'(head), 64'({UNIT_ID_FIRST, 1'b1, 8'h6C, 8'h5A}));
        chk("body", 64'(body), 64'h12_3456_7800_3380);
        reg_read(8'h00, got);
        chk("pending", 64'(got[14]), 64'h1);
    endtask
    task automatic t_eoi();
        i_bpir_host_model.send_eoi(24'h785A34);
        settle(20);
        reg_read(8'h00, got);
        chk("pending", 64'(got[14]), 64'h1);
        i_bpir_host_model.send_eoi(24'h785A00);
        wait_msgs(2);
        pins_n <= 8'hFF;
        settle(6);
        i_bpir_host_model.send_eoi(24'h785A33);
        settle(20);
        reg_read(8'h00, got);
        chk("pending", 64'(got[14]), 64'h0);
        wait_msgs(2);
    endtask
    task automatic t_edge();
        stall <= 4'h5;
        reg_write(8'h20, 32'h0000_2121);
        pins_n <= 8'hEF;
        settle(3);
        pins_n <= 8'hFF;
        wait_msgs(3);
        chk("head", 64'(head), 64'({UNIT_ID_FIRST + 5'h01, 1'b0, 8'h04, 8'h21}));
        chk("body", 64'(body), 64'h0);
        pins_n <= 8'hEF;
        wait_msgs(4);
        i_bpir_host_model.send_eoi(24'h002100);
        settle(60);
        wait_msgs(4);
        pins_n <= 8'hFF;
    endtask
    task automatic t_disc();
        reg_write(8'h00, 32'h0000_A05A);
        disc_n <= 1'b0;
        settle(6);
        pins_n <= 8'hEE;
        settle(80);
        wait_msgs(4);
        disc_n <= 1'b1;
        wait_msgs(6);
        chk("head", 64'(head), 64'({UNIT_ID_FIRST + 5'h01, 1'b0, 8'h04, 8'h21}));
        pins_n <= 8'hFF;
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        settle(5);
        rst_n <= 1'b1;
        settle(3);
        reg_read(8'h00, got);
        chk("entry0_reset", 64'(got), 64'h0001_A000);
        reg_read(8'h60, got);
        chk("unmapped", 64'(got), 64'h0);
        t_legacy();
        t_level();
        t_eoi();
        t_edge();
        t_disc();
        close_out();
    end
endmodule
